// [logic/tmr16_pkg.sv]
/*
 * Shared constants for the 16-bit timer channel: register offsets, field
 * positions, reset values and the mode encodings.
 * Assumes a 32-bit APB register window with one aligned word per register.
 */
package tmr16_pkg;

  // =====================================================================
  // widths
  localparam int CNT_W   = 16;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int PRESC_W = 8;

  // =====================================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MODULE_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RUN_CTRL    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MODE        = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FLOP_CTRL   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MATCH0      = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MATCH1      = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE0    = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE1    = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_COUNTER     = 8'h28;

  // =====================================================================
  // field positions
  localparam int MCTRL_EN_BIT  = 7;
  localparam int RUN_COUNT_BIT = 0;
  localparam int RUN_PRESC_BIT = 2;
  localparam int RUN_DBUF_BIT  = 7;
  localparam int MODE_CLK_LSB  = 0;
  localparam int MODE_CLE_BIT  = 2;
  localparam int MODE_CPM_LSB  = 3;
  localparam int MODE_SWCAP_BIT = 5;
  localparam int FFC_CMD_LSB   = 0;
  localparam int FFC_E0_BIT    = 2;
  localparam int FFC_E1_BIT    = 3;
  localparam int FFC_C0_BIT    = 4;
  localparam int FFC_C1_BIT    = 5;
  localparam int ST_MATCH0_BIT = 0;
  localparam int ST_MATCH1_BIT = 1;
  localparam int ST_OVF_BIT    = 2;
  localparam int ST_CAP1_BIT   = 3;
  localparam int ST_W          = 4;

  // =====================================================================
  // reset values and prescaler tap masks
  localparam logic [CNT_W-1:0] RST_MATCH = 16'h0000;
  localparam logic [ST_W-1:0]  RST_MASK  = 4'h0;
  localparam logic [PRESC_W-1:0] PRESC_MASK_DIV2  = 8'h01;
  localparam logic [PRESC_W-1:0] PRESC_MASK_DIV8  = 8'h07;
  localparam logic [PRESC_W-1:0] PRESC_MASK_DIV32 = 8'h1F;

  // =====================================================================
  // encodings
  typedef enum logic [1:0] {CLK_EXT0, CLK_DIV2, CLK_DIV8, CLK_DIV32}
    tmr16_clk_t;
  typedef enum logic [1:0] {CPM_OFF, CPM_IN0_IN1, CPM_IN0_BOTH, CPM_NBR}
    tmr16_cpm_t;
  typedef enum logic [1:0] {FF_TOGGLE, FF_SET, FF_CLEAR, FF_KEEP}
    tmr16_ffcmd_t;

endpackage : tmr16_pkg

// [logic/tmr16_reg_if.sv]
/*
 * Register access carrier between the APB slave and the timer core.
 * Assumes both ends sit in the pclk domain.
 */
`timescale 1ns/1ps
interface tmr16_reg_if;
  import tmr16_pkg::*;
  logic              wr_stb;   // access-phase write
  logic              rd_stb;   // access-phase read
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;    // core mux, combinational
  logic [DATA_W-1:0] rd_seen;  // value returned to the master
  logic              hit;      // address is mapped

  modport bus  (output wr_stb, rd_stb, addr, wdata, rd_seen,
                input rdata, hit);
  modport core (input wr_stb, rd_stb, addr, wdata, rd_seen,
                output rdata, hit);
endinterface : tmr16_reg_if

// [logic/tmr16_apb.sv]
/*
 * APB slave front end: zero wait states, read data latched in setup.
 * Assumes the core answers rdata and hit combinationally from addr.
 */
`timescale 1ns/1ps
module tmr16_apb
  import tmr16_pkg::*;
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tmr16_pkg::ADDR_W-1:0] paddr,
  input  wire logic [tmr16_pkg::DATA_W-1:0] pwdata,
  output logic      [tmr16_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  tmr16_reg_if.bus                         rif
);
  import tmr16_pkg::*;

  logic [DATA_W-1:0] rdata_q, rdata_d;

  // =====================================================================
  // strobes
  // writes and read side effects act only at the completing edge
  assign rif.wr_stb  = psel & penable & pwrite;
  assign rif.rd_stb  = psel & penable & ~pwrite;
  assign rif.addr    = paddr;
  assign rif.wdata   = pwdata;
  assign rif.rd_seen = rdata_q;
  assign pready      = 1'b1;
  assign pslverr     = psel & penable & ~rif.hit;
  assign prdata      = rdata_q;

  // read data sampled in the setup cycle, unmapped reads give zero
  always_comb begin
    rdata_d = rdata_q;
    if (psel & ~penable & ~pwrite) begin
      rdata_d = rif.hit ? rif.rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule : tmr16_apb

// [logic/tmr16_edge.sv]
/*
 * Rise and fall detectors for a group of synchronous inputs.
 * Assumes inputs already synchronous to pclk.
 */
`timescale 1ns/1ps
module tmr16_edge #(
  parameter int N = 3
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] level,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);
  logic [N-1:0] prev_q, prev_d;

  // =====================================================================
  // one detector per input
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_det
      assign rise[i] = level[i] & ~prev_q[i];
      assign fall[i] = ~level[i] & prev_q[i];
    end
  endgenerate

  always_comb begin
    prev_d = level;
  end

  // reset to low so an input high at release counts as a rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end

endmodule : tmr16_edge

// [logic/tmr16_timer.sv]
/*
 * 16-bit timer channel: up-counter on a prescaler tap or ext_input0,
 * two match registers with optional double buffer on match_reg0, a
 * toggle flop driving timer_out_pin, two capture registers and the
 * match, overflow and capture interrupt flags, all behind APB.
 * Assumes pins synchronous to pclk; neighbor_flop_trigger is the toggle
 * flop of another channel.
 */
// Our own choices: the placing of the registers and the APB slave port.
// Summary of operation
// - match1 hit raises match interrupt
// - event mode counts ext_input0 rising edges
// - software capture copies count into capture0
// - flop toggles on match0 or match1
// - double buffer loads match0 on match1
// - start level set by flop command
// - ext_input0 rise captures into capture0
// - mode 11 captures on neighbor flop edges
// - capture1 load raises capture interrupt
// - with e0 and e1 both set, same-tick match0 and match1 hits cancel
// - capture0 load may toggle the flop
// - no clear means free-running counter
// - width measure uses rise and fall captures
// - flop command toggle/set/clear, reads ones
// - clear enable zeroes counter on match1
// - capture modes 10 and 01 edge sources
// - status flags set, cleared by read
`timescale 1ns/1ps
module tmr16_timer
  import tmr16_pkg::*;
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tmr16_pkg::ADDR_W-1:0] paddr,
  input  wire logic [tmr16_pkg::DATA_W-1:0] pwdata,
  output logic      [tmr16_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        ext_input0,
  input  wire logic                        ext_input1,
  input  wire logic                        neighbor_flop_trigger,
  output logic                             timer_out_pin,
  output logic                             match_irq,
  output logic                             capture_irq
);
  import tmr16_pkg::*;

  // =====================================================================
  // register bus
  tmr16_reg_if rif ();

  tmr16_apb u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rif     (rif)
  );

  // decode shared by all register writes
  function automatic logic is_wr(input logic [ADDR_W-1:0] ofs);
    is_wr = rif.wr_stb && (rif.addr == ofs);
  endfunction : is_wr

  // =====================================================================
  // pin edges: in0, in1, neighbor flop
  logic [2:0] rise, fall;

  tmr16_edge #(.N(3)) u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   ({neighbor_flop_trigger, ext_input1, ext_input0}),
    .rise    (rise),
    .fall    (fall)
  );

  // =====================================================================
  // control registers
  logic              en_q, en_d;
  logic              run_q, run_d;
  logic              presc_run_q, presc_run_d;
  logic              dbuf_q, dbuf_d;
  tmr16_clk_t        clk_sel_q, clk_sel_d;
  logic              clr_en_q, clr_en_d;
  tmr16_cpm_t        cpm_q, cpm_d;
  logic [3:0]        tog_en_q, tog_en_d;   // e0, e1, c0, c1
  logic [ST_W-1:0]   mask_q, mask_d;
  logic              sw_cap;
  tmr16_ffcmd_t      ff_cmd;
  logic              ff_cmd_wr;
  logic              wr_ok;

  // other registers ignore writes while the module is disabled
  assign wr_ok     = en_q;
  assign sw_cap    = is_wr(OFS_MODE) && wr_ok
                     && rif.wdata[MODE_SWCAP_BIT];
  assign ff_cmd    = tmr16_ffcmd_t'(rif.wdata[FFC_CMD_LSB +: 2]);
  assign ff_cmd_wr = is_wr(OFS_FLOP_CTRL) && wr_ok;

  always_comb begin
    en_d        = en_q;
    run_d       = run_q;
    presc_run_d = presc_run_q;
    dbuf_d      = dbuf_q;
    clk_sel_d   = clk_sel_q;
    clr_en_d    = clr_en_q;
    cpm_d       = cpm_q;
    tog_en_d    = tog_en_q;
    mask_d      = mask_q;
    if (is_wr(OFS_MODULE_CTRL)) begin
      en_d = rif.wdata[MCTRL_EN_BIT];
    end
    if (is_wr(OFS_RUN_CTRL) && wr_ok) begin
      run_d       = rif.wdata[RUN_COUNT_BIT];
      presc_run_d = rif.wdata[RUN_PRESC_BIT];
      dbuf_d      = rif.wdata[RUN_DBUF_BIT];
    end
    if (is_wr(OFS_MODE) && wr_ok) begin
      clk_sel_d = tmr16_clk_t'(rif.wdata[MODE_CLK_LSB +: 2]);
      clr_en_d  = rif.wdata[MODE_CLE_BIT];
      cpm_d     = tmr16_cpm_t'(rif.wdata[MODE_CPM_LSB +: 2]);
    end
    if (ff_cmd_wr) begin
      tog_en_d = rif.wdata[FFC_C1_BIT:FFC_E0_BIT];
    end
    if (is_wr(OFS_IRQ_MASK) && wr_ok) begin
      mask_d = rif.wdata[ST_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q        <= 1'b0;
      run_q       <= 1'b0;
      presc_run_q <= 1'b0;
      dbuf_q      <= 1'b0;
      clk_sel_q   <= CLK_EXT0;
      clr_en_q    <= 1'b0;
      cpm_q       <= CPM_OFF;
      tog_en_q    <= 4'h0;
      mask_q      <= RST_MASK;
    end else begin
      en_q        <= en_d;
      run_q       <= run_d;
      presc_run_q <= presc_run_d;
      dbuf_q      <= dbuf_d;
      clk_sel_q   <= clk_sel_d;
      clr_en_q    <= clr_en_d;
      cpm_q       <= cpm_d;
      tog_en_q    <= tog_en_d;
      mask_q      <= mask_d;
    end
  end

  // =====================================================================
  // prescaler and count tick
  logic [PRESC_W-1:0] presc_q, presc_d;
  logic [PRESC_W-1:0] tap_mask;
  logic               tick;

  always_comb begin
    case (clk_sel_q)
      CLK_DIV2:  tap_mask = PRESC_MASK_DIV2;
      CLK_DIV8:  tap_mask = PRESC_MASK_DIV8;
      CLK_DIV32: tap_mask = PRESC_MASK_DIV32;
      default:   tap_mask = '0;
    endcase
  end

  // stopping the prescaler also clears it, so restarts are aligned
  always_comb begin
    presc_d = presc_run_q ? presc_q + 8'h01 : 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 8'h00;
    end else begin
      presc_q <= presc_d;
    end
  end

  // event mode still needs the prescaler run bit set
  always_comb begin
    if (clk_sel_q == CLK_EXT0) begin
      tick = rise[0] & presc_run_q;
    end else begin
      tick = presc_run_q & ((presc_q & tap_mask) == tap_mask);
    end
    tick = tick & run_q & en_q;
  end

  // =====================================================================
  // up-counter and match registers
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] m0_q, m0_d, m1_q, m1_d, buf0_q, buf0_d;
  logic [CNT_W-1:0] cnt_inc;
  logic             hit0, hit1, ovf;

  assign cnt_inc = cnt_q + 16'h0001;
  // a match is flagged on the tick that brings the count onto the value
  assign hit0 = tick && (cnt_inc == m0_q) && !(clr_en_q && cnt_q == m1_q);
  assign hit1 = tick && (cnt_inc == m1_q) && !(clr_en_q && cnt_q == m1_q);
  assign ovf  = tick && (cnt_q == 16'hFFFF)
                && !(clr_en_q && cnt_q == m1_q);

  always_comb begin
    cnt_d = cnt_q;
    if (!run_q) begin
      cnt_d = '0;
    end else if (tick) begin
      if (clr_en_q && cnt_q == m1_q) begin
        cnt_d = '0;
      end else begin
        cnt_d = cnt_inc;
      end
    end
  end

  // with the buffer on, match0 only changes at a match1 hit
  always_comb begin
    m0_d   = m0_q;
    m1_d   = m1_q;
    buf0_d = buf0_q;
    if (is_wr(OFS_MATCH0) && wr_ok) begin
      buf0_d = rif.wdata[CNT_W-1:0];
      if (!dbuf_q) begin
        m0_d = rif.wdata[CNT_W-1:0];
      end
    end
    if (is_wr(OFS_MATCH1) && wr_ok) begin
      m1_d = rif.wdata[CNT_W-1:0];
    end
    if (dbuf_q && hit1) begin
      m0_d = buf0_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      m0_q   <= RST_MATCH;
      m1_q   <= RST_MATCH;
      buf0_q <= RST_MATCH;
    end else begin
      cnt_q  <= cnt_d;
      m0_q   <= m0_d;
      m1_q   <= m1_d;
      buf0_q <= buf0_d;
    end
  end

  // =====================================================================
  // captures
  logic [CNT_W-1:0] cap0_q, cap0_d, cap1_q, cap1_d;
  logic             cap0_ev, cap1_ev;

  always_comb begin
    cap0_ev = sw_cap;
    cap1_ev = 1'b0;
    case (cpm_q)
      CPM_IN0_IN1: begin
        cap0_ev = cap0_ev | rise[0];
        cap1_ev = rise[1];
      end
      CPM_IN0_BOTH: begin
        cap0_ev = cap0_ev | rise[0];
        cap1_ev = fall[0];
      end
      CPM_NBR: begin
        cap0_ev = cap0_ev | rise[2];
        cap1_ev = fall[2];
      end
      default: begin
        cap1_ev = 1'b0;
      end
    endcase
    cap0_ev = cap0_ev & en_q;
    cap1_ev = cap1_ev & en_q;
  end

  always_comb begin
    cap0_d = cap0_ev ? cnt_q : cap0_q;
    cap1_d = cap1_ev ? cnt_q : cap1_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap0_q <= '0;
      cap1_q <= '0;
    end else begin
      cap0_q <= cap0_d;
      cap1_q <= cap1_d;
    end
  end

  // =====================================================================
  // toggle flop
  logic toggle_flop_q, toggle_flop_d;
  logic flop_hw_tog;

  assign flop_hw_tog = (hit0 & tog_en_q[0])
                     ^ (hit1 & tog_en_q[1])
                     ^ (cap0_ev & tog_en_q[2])
                     ^ (cap1_ev & tog_en_q[3]);

  // a toggle, set or clear command overrides a same-cycle hardware toggle
  always_comb begin
    toggle_flop_d = toggle_flop_q ^ flop_hw_tog;
    if (ff_cmd_wr) begin
      case (ff_cmd)
        FF_TOGGLE: toggle_flop_d = ~toggle_flop_q;
        FF_SET:    toggle_flop_d = 1'b1;
        FF_CLEAR:  toggle_flop_d = 1'b0;
        default:   toggle_flop_d = toggle_flop_q ^ flop_hw_tog;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_flop_q <= 1'b0;
    end else begin
      toggle_flop_q <= toggle_flop_d;
    end
  end

  assign timer_out_pin = toggle_flop_q;

  // =====================================================================
  // status flags and interrupt pulses
  logic [ST_W-1:0] st_q, st_d, st_set;
  logic            mirq_q, mirq_d, cirq_q, cirq_d;

  always_comb begin
    st_set                = '0;
    st_set[ST_MATCH0_BIT] = hit0;
    st_set[ST_MATCH1_BIT] = hit1;
    st_set[ST_OVF_BIT]    = ovf;
    st_set[ST_CAP1_BIT]   = cap1_ev;
  end

  // only the bits the master saw are cleared; a new set wins
  always_comb begin
    st_d = st_q;
    if (rif.rd_stb && rif.addr == OFS_IRQ_STATUS) begin
      st_d = st_q & ~rif.rd_seen[ST_W-1:0];
    end
    st_d   = st_d | st_set;
    mirq_d = |(st_set[ST_OVF_BIT:ST_MATCH0_BIT]
               & ~mask_q[ST_OVF_BIT:ST_MATCH0_BIT]);
    cirq_d = cap1_ev & ~mask_q[ST_CAP1_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= '0;
      mirq_q <= 1'b0;
      cirq_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      mirq_q <= mirq_d;
      cirq_q <= cirq_d;
    end
  end

  assign match_irq   = mirq_q;
  assign capture_irq = cirq_q;

  // =====================================================================
  // read mux
  always_comb begin
    rif.rdata = 32'h0000_0000;
    rif.hit   = 1'b1;
    case (rif.addr)
      OFS_MODULE_CTRL: rif.rdata[MCTRL_EN_BIT] = en_q;
      OFS_RUN_CTRL: begin
        rif.rdata[RUN_COUNT_BIT] = run_q;
        rif.rdata[RUN_PRESC_BIT] = presc_run_q;
        rif.rdata[RUN_DBUF_BIT]  = dbuf_q;
      end
      OFS_MODE: begin
        rif.rdata[MODE_CLK_LSB +: 2] = clk_sel_q;
        rif.rdata[MODE_CLE_BIT]      = clr_en_q;
        rif.rdata[MODE_CPM_LSB +: 2] = cpm_q;
        rif.rdata[MODE_SWCAP_BIT]    = 1'b1;
      end
      OFS_FLOP_CTRL: begin
        rif.rdata[FFC_CMD_LSB +: 2]       = FF_KEEP;
        rif.rdata[FFC_C1_BIT:FFC_E0_BIT] = tog_en_q;
      end
      OFS_IRQ_STATUS: rif.rdata[ST_W-1:0]  = st_q;
      OFS_IRQ_MASK:   rif.rdata[ST_W-1:0]  = mask_q;
      OFS_MATCH0:     rif.rdata[CNT_W-1:0] = dbuf_q ? buf0_q : m0_q;
      OFS_MATCH1:     rif.rdata[CNT_W-1:0] = m1_q;
      OFS_CAPTURE0:   rif.rdata[CNT_W-1:0] = cap0_q;
      OFS_CAPTURE1:   rif.rdata[CNT_W-1:0] = cap1_q;
      OFS_COUNTER:    rif.rdata[CNT_W-1:0] = cnt_q;
      default:        rif.hit = 1'b0;
    endcase
  end

endmodule : tmr16_timer

// [testbench/tmr16_checker.sv]
/* Port-level checker for the timer channel.
   Assumes binding to tmr16_timer, one pclk domain. */
`timescale 1ns/1ps
module tmr16_checker
  import tmr16_pkg::*;
(
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [tmr16_pkg::DATA_W-1:0] prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        ext_input0,
  input wire logic                        ext_input1,
  input wire logic                        neighbor_flop_trigger,
  input wire logic                        timer_out_pin,
  input wire logic                        match_irq,
  input wire logic                        capture_irq
);
  // ==========
  // edge history
  logic [2:0] lvl_q;
  logic [2:0] lvl_d;
  logic       evt;
  // capture1 sources: in0 fall, in1 rise, neighbour fall
  always_comb begin
    lvl_d = {neighbor_flop_trigger, ext_input1, ext_input0};
    evt = (lvl_q[0] & ~ext_input0) | (~lvl_q[1] & ext_input1)
        | (lvl_q[2] & ~neighbor_flop_trigger);
  end
  // reset low, as the design's own edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lvl_q <= 3'h0;
    else lvl_q <= lvl_d;
  end
  // ==========
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_quiet;
    !evt ##1 !evt;
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == '0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property
    ($changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("prdata moved without read setup");
  a_match_pulse: assert property (match_irq |=> !match_irq)
    else $error("match irq wider than one cycle");
  a_cap_pulse: assert property (capture_irq |=> !capture_irq)
    else $error("capture irq wider than one cycle");
  a_cap_cause: assert property (s_quiet |=> !$rose(capture_irq))
    else $error("capture irq without capture1 edge");
  a_reset_quiet: assert property
    ($rose(presetn) |-> !(match_irq | capture_irq | timer_out_pin))
    else $error("outputs active after reset");
endmodule : tmr16_checker

bind tmr16_timer tmr16_checker i_tmr16_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_input0(ext_input0), .ext_input1(ext_input1),
  .neighbor_flop_trigger(neighbor_flop_trigger),
  .timer_out_pin(timer_out_pin), .match_irq(match_irq),
  .capture_irq(capture_irq));

// [testbench/tmr16_pins.sv]
/* Far-side model: external pulse sources and neighbour flop.
   Assumes tasks are entered just after a rising pclk edge. */
`timescale 1ns/1ps
module tmr16_pins (
  input  wire logic pclk,
  output logic      ext_input0,
  output logic      ext_input1,
  output logic      neighbor_flop_trigger
);
  // idle low so no stray edge at reset release
  initial begin
    ext_input0 = 1'b0;
    ext_input1 = 1'b0;
    neighbor_flop_trigger = 1'b0;
  end
  // one line set by nonblocking write
  task automatic drive(input int which, input logic v);
    case (which)
      0: ext_input0 <= v;
      1: ext_input1 <= v;
      default: neighbor_flop_trigger <= v;
    endcase
  endtask : drive
  // pulses two cycles high, two low: every level is sampled
  task automatic pulse(input int which, input int k);
    repeat (k) begin
      drive(which, 1'b1);
      repeat (2) @(posedge pclk);
      drive(which, 1'b0);
      repeat (2) @(posedge pclk);
    end
  endtask : pulse
endmodule : tmr16_pins

// [testbench/timer16_modes_capture_ppg_test.sv]
/* Self-checking bench for tmr16_timer over APB with pin model.
   Assumes tmr16_checker is bound and tmr16_pins drives the inputs. */
`timescale 1ns/1ps
module timer16_modes_capture_ppg_test;
  import tmr16_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic              pready, pslverr, in0, in1, nbr, pin, m_irq, c_irq;
  int                errors, checks, cyc, last, highs, ncap, k, kp;
  logic [31:0]       seed;
  logic [32:0]       exp_rd[$];
  int                exp_per[$];
  int                fcmd[5] = '{1, 0, 0, 2, 3};
  int                fpin[5] = '{1, 0, 1, 0, 0};
  int                cpm[4] = '{1, 2, 3, 0};

  tmr16_timer i_tmr16_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_input0(in0), .ext_input1(in1), .neighbor_flop_trigger(nbr),
    .timer_out_pin(pin), .match_irq(m_irq), .capture_irq(c_irq));
  tmr16_pins i_tmr16_pins (.pclk(pclk), .ext_input0(in0),
    .ext_input1(in1), .neighbor_flop_trigger(nbr));

  // ==========
  // clock and helpers
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic stall();
    errors++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    tally_and_finish();
  endtask : stall
  // one APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t == 20) stall();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic err);
    exp_rd.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_q(input int s);
    int t;
    t = 0;
    while (exp_per.size() > s && t < 2000) begin
      @(posedge pclk);
      t++;
    end
    if (t == 2000) stall();
  endtask : wait_q

  // ==========
  // watcher: read data, irq spacing with high time, capture irqs
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_rd.size() > 0)
      chk({pslverr, prdata}, exp_rd.pop_front());
    cyc++;
    highs += (pin === 1'b1);
    if (m_irq === 1'b1) begin
      if (exp_per.size() > 0 && exp_per[0] == 0) void'(exp_per.pop_front());
      else if (exp_per.size() > 0)
        chk((cyc - last) * 256 + highs, exp_per.pop_front());
      last = cyc;
      highs = 0;
    end
    if (c_irq === 1'b1) ncap++;
  end

  // ==========
  // main sequence
  initial begin
    seed = 32'h27;
    {errors, checks, cyc, last, highs, ncap} = '0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(OFS_MATCH1, 32'h55);
    wr(OFS_MODULE_CTRL, 32'h80);
    rd(OFS_MATCH1, 32'h0, 1'b0);
    rd(OFS_MATCH0, RST_MATCH, 1'b0);
    rd(8'h3C, 32'h0, 1'b1);
    // flop commands set, toggle, toggle, clear, keep
    foreach (fcmd[i]) begin
      wr(OFS_FLOP_CTRL, fcmd[i]);
      @(posedge pclk);
      chk(pin, fpin[i]);
    end
    rd(OFS_FLOP_CTRL, 32'h3, 1'b0);
    // interval: clear on match1, pclk/2 ticks
    k = 3 + int'(xs() % 8);
    exp_per = '{0, (2*k+2)*256, (2*k+2)*256, (2*k+2)*256};
    wr(OFS_IRQ_MASK, 32'h5);
    wr(OFS_MATCH1, k);
    wr(OFS_MODE, 32'h5);
    wr(OFS_RUN_CTRL, 32'h5);
    wait_q(0);
    wr(OFS_RUN_CTRL, 32'h0);
    // square wave, start high, buffered match0 change mid-run
    wr(OFS_MATCH0, 32'h2);
    wr(OFS_MATCH1, 32'h7);
    wr(OFS_FLOP_CTRL, 32'hD);
    exp_per = '{0, 16*256+6, 16*256+6, 16*256+6, 16*256+10};
    wr(OFS_RUN_CTRL, 32'h85);
    wait_q(2);
    wr(OFS_MATCH0, 32'h4);
    wait_q(0);
    wr(OFS_FLOP_CTRL, 32'h2);
    wr(OFS_RUN_CTRL, 32'h0);
    // captures, count clock on ext_input0, every timing code
    wr(OFS_MATCH0, 32'hFFF0);
    wr(OFS_MATCH1, 32'hFFF8);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    foreach (cpm[i]) begin
      kp = k;
      k = 1 + int'(xs() % 6);
      wr(OFS_RUN_CTRL, 32'h0);
      wr(OFS_MODE, cpm[i] << 3);
      wr(OFS_RUN_CTRL, 32'h5);
      ncap = 0;
      if (cpm[i] == 3) i_tmr16_pins.drive(2, 1'b1);
      i_tmr16_pins.pulse(0, k);
      if (cpm[i] == 1) i_tmr16_pins.pulse(1, 1);
      if (cpm[i] == 3) i_tmr16_pins.drive(2, 1'b0);
      repeat (3) @(posedge pclk);
      chk(ncap, cpm[i] == 2 ? k : (cpm[i] != 0));
      rd(OFS_CAPTURE0, cpm[i] % 3 ? k - 1 : 0, 1'b0);
      rd(OFS_CAPTURE1, cpm[i] ? k : kp, 1'b0);
      rd(OFS_IRQ_STATUS, cpm[i] ? 32'h8 : 32'h0, 1'b0);
      rd(OFS_IRQ_STATUS, 32'h0, 1'b0);
    end
    rd(OFS_COUNTER, k, 1'b0);
    wr(OFS_MODE, 32'h20);
    rd(OFS_CAPTURE0, k, 1'b0);
    wr(OFS_MATCH0, k + 1);
    wr(OFS_MATCH1, k + 2);
    wr(OFS_FLOP_CTRL, 32'hF);
    i_tmr16_pins.pulse(0, 1);
    chk(pin, 1'b1);
    tally_and_finish();
  end
endmodule : timer16_modes_capture_ppg_test
